// File: common/eeprom_pkg.sv
// package: constants shared by the serial eeprom slave and its bus master
// assumes both ends run on mclk at 125 MHz and meet over the two-wire interface
package eeprom_pkg;
  // ----------------------------------------------------------------
  // array and control byte layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 11;
  localparam int unsigned MEM_BYTES      = 2048;
  localparam logic [3:0]  TYPE_CODE      = 4'h6;  // arbitrary value for the device type code
  localparam int unsigned CTRL_DIR_BIT   = 0;
  localparam logic        DIR_READ       = 1'h1;
  localparam logic        DIR_WRITE      = 1'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS         = 8;
  localparam int unsigned WRITE_TIME_NS  = 5000000;  // self-timed write cycle
  localparam int unsigned WRITE_CYCLES   = (WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GLITCH_NS      = 50;       // spikes shorter than this are dropped
  localparam int unsigned GLITCH_CYCLES  = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SCL_HALF       = 32;       // master scl half period in mclk
  localparam logic [7:0]  FILL_VALUE     = 8'hff;    // erased array content
  // master commands
  typedef enum logic [1:0] {cmd_write, cmd_read_cur, cmd_read_rand, cmd_poll} cmd_type;
endpackage : eeprom_pkg

// File: common/twowire_if.sv
// interface: the two-wire bus joining slave and master, open drain with pull-up
// assumes each party drives low only, enables high while pulling
`timescale 1ns/1ps
interface twowire_if;
  logic scl_oe;      // master pulls scl low
  logic m_sda_oe;    // master pulls sda low
  logic s_sda_oe;    // slave pulls sda low
  logic scl;
  logic sda;
  // ----------------------------------------------------------------
  // wired-and resolution of the pulled-up lines
  // ----------------------------------------------------------------
  assign scl = ~scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport slave  (input scl, input sda, output s_sda_oe);
  modport master (input scl, input sda, output scl_oe, output m_sda_oe);
endinterface : twowire_if

// File: hdl/eeprom_slave.sv
// serial eeprom slave: control byte decode, ack polling, reads with address pointer
// assumes scl and sda come asynchronously from the bus; array held internally
`timescale 1ns/1ps
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYCLES,
  parameter int unsigned FILT_CYC  = GLITCH_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  twowire_if.slave  bus,
  input  wire logic write_protect,
  input  wire logic supply_low,
  output logic      write_busy
);
  typedef enum logic [2:0] {st_idle, st_ctrl, st_addr, st_wdata, st_rdata, st_rack} state_type;

  // ----------------------------------------------------------------
  // synchronisers and spike filters
  // ----------------------------------------------------------------
  logic [1:0] scl_sync, sda_sync, wp_sync, low_sync;
  logic       scl_f, sda_f, scl_d, sda_d;
  logic [7:0] scl_cnt, sda_cnt;

  // two flops for every asynchronous input
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      low_sync <= 2'h0;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      wp_sync  <= {wp_sync[0], write_protect};
      low_sync <= {low_sync[0], supply_low};
    end
  end

  // a line changes only after staying at its new level FILT_CYC cycles
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_f   <= 1'h1;
      sda_f   <= 1'h1;
      scl_cnt <= 8'h0;
      sda_cnt <= 8'h0;
    end else begin
      if (scl_sync[1] == scl_f) scl_cnt <= 8'h0;
      else if (scl_cnt == 8'(FILT_CYC - 1)) begin
        scl_f   <= scl_sync[1];
        scl_cnt <= 8'h0;
      end else scl_cnt <= scl_cnt + 8'h1;
      if (sda_sync[1] == sda_f) sda_cnt <= 8'h0;
      else if (sda_cnt == 8'(FILT_CYC - 1)) begin
        sda_f   <= sda_sync[1];
        sda_cnt <= 8'h0;
      end else sda_cnt <= sda_cnt + 8'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  logic [7:0]        mem [MEM_BYTES];
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] waddr;
  logic [7:0]        shreg;
  logic [3:0]        bitn;
  logic              ack_slot, pending, wr_valid, master_ack;
  logic [7:0]        wdata;
  logic [31:0]       wcnt;
  state_type         state;

  // byte-level state; bit count runs 0..7 data then 8 ack slot
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= st_idle;
      bitn       <= 4'h0;
      shreg      <= 8'h0;
      ptr        <= '0;
      waddr      <= '0;
      ack_slot   <= 1'h0;
      pending    <= 1'h0;
      wr_valid   <= 1'h0;
      wdata      <= 8'h0;
      master_ack <= 1'h0;
    end else if (start_ev) begin
      state    <= st_ctrl;  // restart drops the write, pointer already loaded
      bitn     <= 4'hf;  // the start's own scl fall wraps this to zero
      ack_slot <= 1'h0;
      wr_valid <= 1'h0;
    end else if (stop_ev) begin
      state    <= st_idle;
      ack_slot <= 1'h0;
      pending  <= wr_valid;
      wr_valid <= 1'h0;
    end else if (scl_rise) begin
      if (bitn == 4'h8) begin
        master_ack <= ~sda_f;
      end else if (state != st_rdata) begin
        shreg <= {shreg[6:0], sda_f};
      end
    end else if (scl_fall && state != st_idle) begin
      if (bitn == 4'h7) begin
        bitn <= 4'h8;
        unique case (state)
          st_ctrl: begin
            // busy write cycle hides the device entirely
            if (shreg[7:4] == TYPE_CODE && !write_busy) begin
              ack_slot <= 1'h1;
              ptr[ADDR_W-1:8] <= shreg[3:1];
              state <= (shreg[CTRL_DIR_BIT] == DIR_READ) ? st_rdata : st_addr;
              if (shreg[CTRL_DIR_BIT] == DIR_READ) shreg <= mem[ptr];
            end else state <= st_idle;
          end
          st_addr: begin
            ack_slot <= 1'h1;
            ptr[7:0] <= shreg;
            state    <= st_wdata;
          end
          st_wdata: begin
            ack_slot <= 1'h1;
            wdata    <= shreg;
            wr_valid <= 1'h1;
            waddr    <= ptr;
            ptr      <= ptr + 1'b1;  // a write moves the pointer too
          end
          st_rdata: begin
            ack_slot <= 1'h0;
            ptr      <= ptr + 1'b1;  // natural wrap
          end
          default: state <= st_idle;
        endcase
      end else if (bitn == 4'h8) begin
        bitn     <= 4'h0;
        ack_slot <= 1'h0;
        if (state == st_rdata && ack_slot) begin
          shreg <= mem[ptr];  // control byte ack done, first byte
        end else if (state == st_rdata) begin
          if (master_ack) shreg <= mem[ptr];
          else state <= st_idle;  // release and wait for stop
        end
      end else begin
        bitn <= bitn + 4'h1;
        if (state == st_rdata) shreg <= {shreg[6:0], 1'h1};  // msb first
      end
    end else if (write_busy) begin
      pending <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // self-timed write cycle; byte written at waddr, the pointer having already moved on when the byte arrived
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      write_busy <= 1'h0;
      wcnt       <= 32'h0;
    end else if (pending && !write_busy) begin
      write_busy <= 1'h1;
      wcnt       <= 32'(WRITE_CYC - 1);
    end else if (write_busy) begin
      if (wcnt == 32'h0) write_busy <= 1'h0;
      else wcnt <= wcnt - 32'h1;
    end
  end

  // array update; protection and low supply gate the store
  always_ff @(posedge mclk) begin
    if (pending && !write_busy && !wp_sync[1] && !low_sync[1]) begin
      mem[waddr] <= wdata;
    end
  end

  // data line: pull low for ack or a zero data bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) bus.s_sda_oe <= 1'h0;
    else if (start_ev || stop_ev) bus.s_sda_oe <= 1'h0;
    else if (scl_fall) begin
      if (bitn == 4'h7 && state == st_ctrl)
        bus.s_sda_oe <= shreg[7:4] == TYPE_CODE && !write_busy;
      else if (bitn == 4'h7 && (state == st_addr || state == st_wdata))
        bus.s_sda_oe <= 1'h1;
      else if (bitn == 4'h8 && state == st_rdata && (ack_slot || master_ack))
        bus.s_sda_oe <= ~mem[ptr][7];
      else if (bitn < 4'h7 && state == st_rdata)
        bus.s_sda_oe <= ~shreg[6];
      else bus.s_sda_oe <= 1'h0;
    end
  end
endmodule : eeprom_slave

// File: hdl/eeprom_master.sv
// two-wire master: runs one write, current read, random read or poll per command
// assumes the slave on the same interface; scl made by dividing mclk
`timescale 1ns/1ps
module eeprom_master
  import eeprom_pkg::*;
#(
  parameter int unsigned HALF = SCL_HALF
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  twowire_if.master        bus,
  input  wire logic        cmd_valid,
  input  cmd_type          cmd,
  input  wire logic [10:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic [7:0]  cmd_count,
  output logic             cmd_ready,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             nacked
);
  typedef enum logic [2:0] {ph_idle, ph_start, ph_bit, ph_stop, ph_done} phase_type;

  logic [1:0] sda_sync;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) sda_sync <= 2'h3;
    else sda_sync <= {sda_sync[0], bus.sda};
  end

  // ----------------------------------------------------------------
  // byte script: ctrl, address, data, restart, ctrl read, reads
  // ----------------------------------------------------------------
  phase_type  ph;
  cmd_type    op;
  logic [7:0] tick, shreg, left;
  logic [3:0] bitn;
  logic [2:0] stage;     // 0 ctrl 1 addr 2 data 3 read ctrl 4 reads
  logic [1:0] q;         // quarter of the bit period
  logic [10:0] addr;
  logic [7:0] wbyte;

  function automatic logic [7:0] ctrl_byte(input logic [10:0] a, input logic dir);
    return {TYPE_CODE, a[10:8], dir};
  endfunction : ctrl_byte

  // one bit spends four quarter slots: sda set, scl high, sample, scl low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= ph_idle; op <= cmd_write; tick <= 8'h0; shreg <= 8'h0; left <= 8'h0;
      bitn <= 4'h0; stage <= 3'h0; q <= 2'h0; addr <= '0; wbyte <= 8'h0;
      cmd_ready <= 1'h1; rd_valid <= 1'h0; rd_data <= 8'h0; nacked <= 1'h0;
      bus.scl_oe <= 1'h0; bus.m_sda_oe <= 1'h0;
    end else begin
      rd_valid <= 1'h0;
      if (ph != ph_idle && tick != 8'(HALF / 2 - 1)) tick <= tick + 8'h1;
      else if (ph == ph_idle) begin
        if (cmd_valid) begin
          op <= cmd; addr <= cmd_addr; wbyte <= cmd_data; left <= cmd_count;
          cmd_ready <= 1'h0; nacked <= 1'h0; ph <= ph_start; q <= 2'h0; tick <= 8'h0;
          stage <= (cmd == cmd_read_cur) ? 3'h3 : 3'h0;
        end
      end else begin
        tick <= 8'h0;
        q    <= q + 2'h1;
        unique case (ph)
          ph_start: begin  // sda falls with scl high, then scl low
            if (q == 2'h0) begin bus.m_sda_oe <= 1'h0; end
            if (q == 2'h1) bus.scl_oe <= 1'h0;
            if (q == 2'h2) bus.m_sda_oe <= 1'h1;
            if (q == 2'h3) begin
              bus.scl_oe <= 1'h1; ph <= ph_bit; bitn <= 4'h0;
              shreg <= (stage == 3'h3) ? ctrl_byte(addr, DIR_READ) : ctrl_byte(addr, DIR_WRITE);
            end
          end
          ph_bit: begin
            if (q == 2'h0) begin
              if (bitn == 4'h8) bus.m_sda_oe <= (stage == 3'h4) && (left != 8'h1);
              else if (stage == 3'h4) bus.m_sda_oe <= 1'h0;
              else bus.m_sda_oe <= ~shreg[7];
            end
            if (q == 2'h1) bus.scl_oe <= 1'h0;
            if (q == 2'h2 && bitn != 4'h8) shreg <= {shreg[6:0], sda_sync[1]};
            if (q == 2'h2 && bitn == 4'h8 && stage != 3'h4 && sda_sync[1]) nacked <= 1'h1;
            if (q == 2'h3) begin
              bus.scl_oe <= 1'h1;
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if (nacked) ph <= ph_stop;
                else unique case (stage)
                  3'h0: if (op == cmd_poll) ph <= ph_stop;
                        else begin stage <= 3'h1; shreg <= addr[7:0]; end
                  3'h1: if (op == cmd_write) begin stage <= 3'h2; shreg <= wbyte; end
                        else begin stage <= 3'h3; ph <= ph_start; end
                  3'h2: ph <= ph_stop;
                  3'h3: stage <= 3'h4;
                  default: begin
                    left <= left - 8'h1;
                    if (left == 8'h1) ph <= ph_stop;
                  end
                endcase
              end else if (bitn == 4'h7 && stage == 3'h4) begin
                rd_valid <= 1'h1; rd_data <= shreg;
              end
            end
          end
          ph_stop: begin  // sda rises with scl high
            if (q == 2'h0) bus.m_sda_oe <= 1'h1;
            if (q == 2'h1) bus.scl_oe <= 1'h0;
            if (q == 2'h2) bus.m_sda_oe <= 1'h0;
            if (q == 2'h3) ph <= ph_done;
          end
          default: begin ph <= ph_idle; cmd_ready <= 1'h1; end
        endcase
      end
    end
  end
endmodule : eeprom_master

// File: sim/eeprom_chk.sv
// checker: bus release and write timer properties of the eeprom link
// assumes the interface signals plus the slave busy flag, all on mclk
`timescale 1ns/1ps
module eeprom_chk #(
  parameter int unsigned WRITE_CYC = 2000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic write_busy
);
  logic        sda_d;
  logic        scl_d;
  logic        in_frame;
  logic [7:0]  stop_age;
  logic [31:0] busy_cnt;
  wire         start_ev = scl && scl_d && sda_d && !sda;
  wire         stop_ev  = scl && scl_d && !sda_d && sda;
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // delayed lines give edge events without sampled functions
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_d <= sda;
      scl_d <= scl;
    end
  end
  // frame flag between start and stop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) in_frame <= 1'b0;
    else if (start_ev) in_frame <= 1'b1;
    else if (stop_ev) in_frame <= 1'b0;
  end
  // saturating age of the last stop, so busy onset can be tied to it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) stop_age <= 8'hff;
    else if (stop_ev) stop_age <= 8'h00;
    else if (stop_age != 8'hff) stop_age <= stop_age + 8'h01;
  end
  // length of the current busy spell
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) busy_cnt <= 32'h0;
    else if (write_busy) busy_cnt <= busy_cnt + 32'h1;
    else busy_cnt <= 32'h0;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  no_ack_busy_a: assert property (write_busy |-> !s_sda_oe)
    else $error("slave pulled sda during write cycle");
  busy_len_a: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYC)
    else $error("write cycle length wrong");
  busy_start_a: assert property ($rose(write_busy) |-> stop_age < 8'd24)
    else $error("write cycle began without a stop");
  sda_low_change_a: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave changed sda while scl high");
  single_drv_a: assert property (scl && scl_d |-> !(s_sda_oe && m_sda_oe))
    else $error("both parties pulled sda during scl high");
  stop_free_a: assert property (stop_ev |-> !s_sda_oe)
    else $error("slave held sda at stop");
  start_free_a: assert property (start_ev |-> !s_sda_oe)
    else $error("slave held sda at start");
  idle_free_a: assert property (!in_frame |-> !s_sda_oe && !scl_oe)
    else $error("bus not released outside a frame");
endmodule : eeprom_chk

// File: sim/tb.sv
// testbench: slave and master joined over one two-wire link
// assumes a write cycle shortened to WCYC cycles; scl divider left at default
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  localparam int unsigned WCYC = 2000;
  logic        mclk;
  logic        rst_b;
  logic        write_protect;
  logic        supply_low;
  logic        write_busy;
  logic        cmd_valid;
  cmd_type     cmd;
  logic [10:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic [7:0]  cmd_count;
  logic        cmd_ready;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        nacked;
  logic [7:0]  rx[$];
  int          err_count = 0;
  int          cmp_count = 0;
  twowire_if bus ();
  eeprom_slave #(.WRITE_CYC(WCYC)) eeprom_slave_i (.mclk(mclk), .rst_b(rst_b), .bus(bus),
    .write_protect(write_protect), .supply_low(supply_low), .write_busy(write_busy));
  eeprom_master eeprom_master_i (.mclk(mclk), .rst_b(rst_b), .bus(bus), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .nacked(nacked));
  eeprom_chk #(.WRITE_CYC(WCYC)) eeprom_chk_i (.mclk(mclk), .rst_b(rst_b),
    .scl_oe(bus.scl_oe), .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe),
    .scl(bus.scl), .sda(bus.sda), .write_busy(write_busy));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  // one command: held until taken, then read bytes gathered until ready returns
  task automatic run_cmd(input cmd_type c, input logic [10:0] a, input logic [7:0] d,
                         input logic [7:0] n);
    int t;
    rx.delete();
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    cmd_addr  <= a;
    cmd_data  <= d;
    cmd_count <= n;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge mclk);
      if (rd_valid === 1'b1) rx.push_back(rd_data);
      t++;
    end while ((cmd_ready !== 1'b1 || t < 2) && t < 20000);
    if (t >= 20000) check_flag(1'b0, 1'b1);
  endtask : run_cmd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // write one byte, then poll: refused while busy, accepted after
  task automatic t_write_poll(input logic [10:0] a, input logic [7:0] d);
    int i;
    run_cmd(cmd_write, a, d, 8'h01);
    check_flag(write_busy, 1'b1);
    run_cmd(cmd_poll, a, 8'h00, 8'h01);
    check_flag(nacked, 1'b1);
    for (i = 0; i < 8 && nacked !== 1'b0; i++) run_cmd(cmd_poll, a, 8'h00, 8'h01);
    check_flag(nacked, 1'b0);
    check_flag(write_busy, 1'b0);
  endtask : t_write_poll
  // current read after the write to 000, random read across the top, current read again
  task automatic t_reads;
    run_cmd(cmd_read_cur, 11'h000, 8'h00, 8'h01);
    check_byte(rx[0], 8'h3c);
    run_cmd(cmd_read_rand, 11'h7ff, 8'h00, 8'h02);
    check_flag(write_busy, 1'b0);
    check_byte(8'(rx.size()), 8'h02);
    check_byte(rx[0], 8'h5a);
    check_byte(rx[1], 8'ha5);
    run_cmd(cmd_read_cur, 11'h000, 8'h00, 8'h01);
    check_byte(rx[0], 8'h3c);
  endtask : t_reads
  // writes under protect, then under low supply, must leave the array alone
  task automatic t_blocked;
    int i;
    logic [7:0] keep[2];
    keep[0] = 8'ha5;
    keep[1] = 8'h3c;
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      write_protect <= (i == 0);
      supply_low    <= (i == 1);
      t_write_poll(11'(i), 8'h00);
      @(posedge mclk);
      write_protect <= 1'b0;
      supply_low    <= 1'b0;
      run_cmd(cmd_read_rand, 11'(i), 8'h00, 8'h01);
      check_byte(rx[0], keep[i]);
    end
  endtask : t_blocked
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #(CLK_NS / 2) mclk = ~mclk;
  end
  // the tests need about 31k cycles; 80k, over twice that, means a hang
  initial begin
    #(CLK_NS * 80000);
    err_count++;
    finish_test();
  end
  initial begin
    rst_b         = 1'b0;
    write_protect = 1'b0;
    supply_low    = 1'b0;
    cmd_valid     = 1'b0;
    cmd           = cmd_write;
    cmd_addr      = 11'h000;
    cmd_data      = 8'h00;
    cmd_count     = 8'h01;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_write_poll(11'h7ff, 8'h5a);
    t_write_poll(11'h001, 8'h3c);
    t_write_poll(11'h000, 8'ha5);
    t_reads();
    t_blocked();
    finish_test();
  end
endmodule : tb
